// [hw/uerr_regs.sv]
// USB error interrupt enables, error flags and frame number capture behind AXI4-Lite
// Operation
// RULE1 - Enable bit 7 lets a bit stuffing error raise the interrupt when 1 and blocks it when 0.
// RULE2 - Enable bit 6 gates the bus access error interrupt the same way.
// RULE3 - Enable bit 5 gates the DMA error interrupt the same way.
// RULE4 - Enable bit 4 gates the bus turnaround time-out interrupt the same way.
// RULE5 - Enable bit 2 gates the CRC16 data packet failure interrupt the same way.
// RULE6 - Enable bit 1 gates the CRC5 token error interrupt the same way.
// RULE7 - Enable bit 0 gates the PID check failure interrupt the same way.
// RULE8 - The frame number low register shows frame number bits 7 to 0, read-only.
// RULE9 - Every received start-of-frame token loads its frame number.
// RULE10 - Bits 15 to 8 of the frame number low register read zero and ignore writes.
// RULE11 - Enable bit 3 gates the data field size error interrupt the same way.
// RULE12 - The interrupt is high while any set error flag has its enable at 1; enables reset to 0.
`default_nettype none
module uerr_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] err_event,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  output logic usb_err_irq
);
  logic [7:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic [7:0] err_irq_en_reg;
  logic [7:0] err_status_reg;
  logic [10:0] frame_reg;
  logic do_write;
  logic clr_hit;
  logic [7:0] clr_mask;
  logic [31:0] rdata_next;
  logic rd_ok_next;

  // Address and data are latched separately so either may come first
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_full_reg <= 1'b0;
    end
  end

  // Ready only while the holding slot is empty and no response is pending
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_full_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign clr_hit = do_write && (aw_addr_reg == uerr_pkg::ERR_CLEAR_OFF) && w_strb_reg[0];
  assign clr_mask = clr_hit ? w_data_reg[7:0] : 8'h00;

  // Write response; unmapped or read-only targets answer SLVERR, except the read-only frame low register, which answers OKAY
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uerr_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg == uerr_pkg::ERR_IRQ_EN_OFF || aw_addr_reg == uerr_pkg::ERR_CLEAR_OFF)
        s_axi_bresp <= uerr_pkg::RESP_OKAY;
      else if (aw_addr_reg == uerr_pkg::FRAME_LOW_OFF)
        s_axi_bresp <= uerr_pkg::RESP_OKAY; // Writes dropped, see RULE10
      else
        s_axi_bresp <= uerr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Enable register; only the low byte lane holds bits, upper bits are reserved
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      err_irq_en_reg <= uerr_pkg::ERR_IRQ_EN_RST; // see RULE12
    else if (do_write && aw_addr_reg == uerr_pkg::ERR_IRQ_EN_OFF && w_strb_reg[0])
      err_irq_en_reg <= w_data_reg[7:0]; // see RULE1 see RULE2 see RULE3 see RULE4
  end

  // Sticky error flags; a new event wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      err_status_reg <= 8'h00;
    else
      err_status_reg <= (err_status_reg & ~clr_mask) | err_event;
  end

  // Frame number capture on each start-of-frame token
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      frame_reg <= uerr_pkg::FRAME_RST;
    else if (sof_valid)
      frame_reg <= sof_frame; // see RULE9
  end

  // One interrupt from any flagged enabled source, registered so the output is a flop
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      usb_err_irq <= 1'b0;
    else
      usb_err_irq <= |(err_status_reg & err_irq_en_reg); // see RULE5 see RULE6 see RULE7 see RULE11 see RULE12
  end

  // Read mux
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    rd_ok_next = 1'b1;
    case (s_axi_araddr)
      uerr_pkg::ERR_IRQ_EN_OFF: rdata_next = {24'h00_0000, err_irq_en_reg};
      uerr_pkg::FRAME_LOW_OFF: rdata_next = {24'h00_0000, frame_reg[7:0]}; // see RULE8 see RULE10
      uerr_pkg::ERR_STATUS_OFF: rdata_next = {24'h00_0000, err_status_reg};
      uerr_pkg::ERR_CLEAR_OFF: rdata_next = 32'h0000_0000;
      uerr_pkg::FRAME_FULL_OFF: rdata_next = {21'h0_0000, frame_reg};
      default: rd_ok_next = 1'b0;
    endcase
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uerr_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rd_ok_next ? uerr_pkg::RESP_OKAY : uerr_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks; the line lags the flags by one flop, so it is held against the past product
  property p_irq_gate;
    @(posedge sys_clk) disable iff (!rst_b)
      usb_err_irq == $past(|(err_status_reg & err_irq_en_reg));
  endproperty
  a_irq_gate: assert property (p_irq_gate) // see RULE12
    else $error("irq does not follow enabled flags");
  property p_all_blocked;
    @(posedge sys_clk) disable iff (!rst_b)
      (err_irq_en_reg == 8'h00) ##1 (err_irq_en_reg == 8'h00) |-> !usb_err_irq;
  endproperty
  a_all_blocked: assert property (p_all_blocked) // see RULE12
    else $error("irq with all enables clear");
  property p_sof_load;
    @(posedge sys_clk) disable iff (!rst_b) sof_valid |=> frame_reg == $past(sof_frame);
  endproperty
  a_sof_load: assert property (p_sof_load) // see RULE9
    else $error("frame not loaded on SOF");
  property p_frame_read;
    @(posedge sys_clk) disable iff (!rst_b)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == uerr_pkg::FRAME_LOW_OFF
      |=> s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[7:0] == $past(frame_reg[7:0]);
  endproperty
  a_frame_read: assert property (p_frame_read) // see RULE8
    else $error("frame low read wrong");
  property p_event_sticky;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::BIT_STUFF_BIT] |=> err_status_reg[uerr_pkg::BIT_STUFF_BIT];
  endproperty
  a_event_sticky: assert property (p_event_sticky) // see RULE1
    else $error("error event lost");
  property p_bvalid_hold;
    @(posedge sys_clk) disable iff (!rst_b) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("bvalid dropped early");
  // An enabled source lifts the line two edges after its event: one to flag, one to register
  property p_bit_stuff_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::BIT_STUFF_BIT] && err_irq_en_reg[uerr_pkg::BIT_STUFF_BIT]
      ##1 err_irq_en_reg[uerr_pkg::BIT_STUFF_BIT] |=> usb_err_irq;
  endproperty
  a_bit_stuff_raise: assert property (p_bit_stuff_raise) // see RULE1
    else $error("bit stuff error did not raise irq");
  property p_bus_access_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::BUS_ACCESS_BIT] && err_irq_en_reg[uerr_pkg::BUS_ACCESS_BIT]
      ##1 err_irq_en_reg[uerr_pkg::BUS_ACCESS_BIT] |=> usb_err_irq;
  endproperty
  a_bus_access_raise: assert property (p_bus_access_raise) // see RULE2
    else $error("bus access error did not raise irq");
  property p_dma_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::DMA_ERR_BIT] && err_irq_en_reg[uerr_pkg::DMA_ERR_BIT]
      ##1 err_irq_en_reg[uerr_pkg::DMA_ERR_BIT] |=> usb_err_irq;
  endproperty
  a_dma_raise: assert property (p_dma_raise) // see RULE3
    else $error("dma error did not raise irq");
  property p_turnaround_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::TURNAROUND_BIT] && err_irq_en_reg[uerr_pkg::TURNAROUND_BIT]
      ##1 err_irq_en_reg[uerr_pkg::TURNAROUND_BIT] |=> usb_err_irq;
  endproperty
  a_turnaround_raise: assert property (p_turnaround_raise) // see RULE4
    else $error("turnaround time-out did not raise irq");
  property p_crc16_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::CRC16_FAIL_BIT] && err_irq_en_reg[uerr_pkg::CRC16_FAIL_BIT]
      ##1 err_irq_en_reg[uerr_pkg::CRC16_FAIL_BIT] |=> usb_err_irq;
  endproperty
  a_crc16_raise: assert property (p_crc16_raise) // see RULE5
    else $error("crc16 failure did not raise irq");
  property p_crc5_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::CRC5_HOST_BIT] && err_irq_en_reg[uerr_pkg::CRC5_HOST_BIT]
      ##1 err_irq_en_reg[uerr_pkg::CRC5_HOST_BIT] |=> usb_err_irq;
  endproperty
  a_crc5_raise: assert property (p_crc5_raise) // see RULE6
    else $error("crc5 error did not raise irq");
  property p_pid_check_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::PID_CHECK_BIT] && err_irq_en_reg[uerr_pkg::PID_CHECK_BIT]
      ##1 err_irq_en_reg[uerr_pkg::PID_CHECK_BIT] |=> usb_err_irq;
  endproperty
  a_pid_check_raise: assert property (p_pid_check_raise) // see RULE7
    else $error("pid check failure did not raise irq");
  property p_data_field_raise;
    @(posedge sys_clk) disable iff (!rst_b)
      err_event[uerr_pkg::DATA_FIELD_BIT] && err_irq_en_reg[uerr_pkg::DATA_FIELD_BIT]
      ##1 err_irq_en_reg[uerr_pkg::DATA_FIELD_BIT] |=> usb_err_irq;
  endproperty
  a_data_field_raise: assert property (p_data_field_raise) // see RULE11
    else $error("data field size error did not raise irq");
  // A flagged source with its enable at 0 must not lift the line by itself
  for (genvar gi = 0; gi < uerr_pkg::ERR_COUNT; gi++)
  begin : g_src_blocked
    property p_src_blocked;
      @(posedge sys_clk) disable iff (!rst_b)
        err_status_reg[gi] && !err_irq_en_reg[gi] && ((err_status_reg & err_irq_en_reg) == 8'h00) |=> !usb_err_irq;
    endproperty
    a_src_blocked: assert property (p_src_blocked) // see RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE11
      else $error("disabled error source raised irq");
  end
  // A bus write to the frame low word must leave the captured number alone
  property p_frame_write_ignored;
    @(posedge sys_clk) disable iff (!rst_b)
      do_write && aw_addr_reg == uerr_pkg::FRAME_LOW_OFF && !sof_valid |=> $stable(frame_reg);
  endproperty
  a_frame_write_ignored: assert property (p_frame_write_ignored) // see RULE10
    else $error("frame number changed by a bus write");
  c_sof: cover property (@(posedge sys_clk) disable iff (!rst_b) sof_valid);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(usb_err_irq));
  c_write: cover property (@(posedge sys_clk) disable iff (!rst_b) do_write);
endmodule // uerr_regs
`default_nettype wire

// [shared/uerr_pkg.sv]
// Package for the USB error interrupt enable and frame number low register slice
`default_nettype none
package uerr_pkg;
  // Register byte offsets
  localparam logic [7:0] ERR_IRQ_EN_OFF = 8'h00;
  localparam logic [7:0] FRAME_LOW_OFF = 8'h04;
  localparam logic [7:0] ERR_STATUS_OFF = 8'h08;
  localparam logic [7:0] ERR_CLEAR_OFF = 8'h0C;
  localparam logic [7:0] FRAME_FULL_OFF = 8'h10;
  // Error enable bit positions
  localparam int PID_CHECK_BIT = 0;
  localparam int CRC5_HOST_BIT = 1;
  localparam int CRC16_FAIL_BIT = 2;
  localparam int DATA_FIELD_BIT = 3;
  localparam int TURNAROUND_BIT = 4;
  localparam int DMA_ERR_BIT = 5;
  localparam int BUS_ACCESS_BIT = 6;
  localparam int BIT_STUFF_BIT = 7;
  localparam int ERR_COUNT = 8;
  localparam int FRAME_WIDTH = 11;
  // Reset values
  localparam logic [7:0] ERR_IRQ_EN_RST = 8'h00;
  localparam logic [10:0] FRAME_RST = 11'h000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [testbench/uerr_usb_far.sv]
// Far-side USB partner model: error pulses and start-of-frame tokens
`default_nettype none
module uerr_usb_far (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] ev_req,
  input wire logic sof_req,
  input wire logic [10:0] frame_req,
  output logic [7:0] err_event,
  output logic sof_valid,
  output logic [10:0] sof_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle pulses; released frame lines flip so stale values never match
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_event <= 8'h00;
      sof_valid <= 1'h0;
      sof_frame <= 11'h000;
    end
    else
    begin
      err_event <= ev_req;
      sof_valid <= sof_req;
      if (sof_req)
        sof_frame <= frame_req;
      else if (sof_valid)
        sof_frame <= ~sof_frame;
    end
  end
endmodule // uerr_usb_far
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the USB error enable and frame number registers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = uerr_pkg::RESP_OKAY;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, sof_req = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, usb_err_irq, sof_valid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ev_req = 8'h00, err_event, b;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h3F40E8CB;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [10:0] frame_req = 11'h000, sof_frame, frame_exp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  uerr_regs uerr_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .err_event(err_event),
    .sof_valid(sof_valid), .sof_frame(sof_frame), .usb_err_irq(usb_err_irq));
  uerr_usb_far uerr_usb_far_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ev_req(ev_req), .sof_req(sof_req),
    .frame_req(frame_req), .err_event(err_event), .sof_valid(sof_valid), .sof_frame(sof_frame));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic bad(input logic [33:0] e, input logic [33:0] a);
    num_errors++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
  endtask
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] a);
    n_checks++;
    if (a !== e) bad(e, a);
  endtask
  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] a);
    n_checks++;
    if (a !== e) bad({32'h0, e}, {32'h0, a});
  endtask
  task automatic cmp_irq(input logic e);
    n_checks++;
    if (usb_err_irq !== e) bad({33'h0, e}, {33'h0, usb_err_irq});
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
  endtask
  // Read: expected word noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge sys_clk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    rready <= 1'h0;
  endtask
  // Error pulse, then room for status and interrupt to settle
  task automatic ev(input logic [7:0] v);
    @(posedge sys_clk);
    ev_req <= v;
    @(posedge sys_clk);
    ev_req <= 8'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  // Start-of-frame token carrying one frame number
  task automatic sof(input logic [10:0] f);
    @(posedge sys_clk);
    sof_req <= 1'h1;
    frame_req <= f;
    @(posedge sys_clk);
    sof_req <= 1'h0;
  endtask
  // Response checker and hang guard; a read result is matched to its oldest note
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      num_errors++;
      stop_test();
    end
    if (rvalid && rready) cmp_rd(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) cmp_resp(bq.pop_front(), bresp);
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    rd(uerr_pkg::ERR_IRQ_EN_OFF, {OK, 32'h0});
    rd(uerr_pkg::FRAME_LOW_OFF, {OK, 32'h0});
    wr(uerr_pkg::ERR_IRQ_EN_OFF, 32'hFFFFFFFF, OK);
    rd(uerr_pkg::ERR_IRQ_EN_OFF, {OK, 32'hFF});
    // Each enable alone: other sources must stay silent, its own must fire
    for (int i = 0; i < uerr_pkg::ERR_COUNT; i++)
    begin
      b = 8'h01 << i;
      seed = lfsr(seed);
      wr(uerr_pkg::ERR_IRQ_EN_OFF, {24'h0, b}, OK);
      wr(uerr_pkg::ERR_CLEAR_OFF, 32'hFF, OK);
      ev(seed[7:0] & ~b);
      cmp_irq(1'h0);
      ev(b);
      cmp_irq(1'h1);
      rd(uerr_pkg::ERR_STATUS_OFF, {OK, 24'h0, seed[7:0] | b});
      wr(uerr_pkg::ERR_CLEAR_OFF, {24'h0, b}, OK);
      ev(8'h00);
      cmp_irq(1'h0);
    end
    // Two tokens from unrelated seed bits; the partner's flipped idle lines must not load
    seed = lfsr(seed);
    sof(seed[10:0]);
    seed = lfsr(seed);
    frame_exp = seed[26:16];
    sof(frame_exp);
    repeat (2) @(posedge sys_clk);
    rd(uerr_pkg::FRAME_LOW_OFF, {OK, 24'h0, frame_exp[7:0]});
    rd(uerr_pkg::FRAME_FULL_OFF, {OK, 21'h0, frame_exp});
    wr(uerr_pkg::FRAME_LOW_OFF, 32'hFFFF, OK);
    rd(uerr_pkg::FRAME_LOW_OFF, {OK, 24'h0, frame_exp[7:0]});
    wr(uerr_pkg::ERR_STATUS_OFF, 32'h0, uerr_pkg::RESP_SLVERR);
    rd(8'h20, {uerr_pkg::RESP_SLVERR, 32'h0});
    stop_test();
  end
endmodule // tb
`default_nettype wire
